// [design/drtw_sync.sv]
/*
 * drtw_sync: two-flop synchroniser with a rising-edge strobe.
 * Assumes raw comes from another clock or a pin and is held long
 * enough (four-phase handshake) to be seen at 100 MHz.
 */
`default_nettype none

module drtw_sync #(parameter int W = 8) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_b,
    // levels in and out
    drtw_sync_if.dst s
);
    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;
    logic [W-1:0] prev_q;

    // first stage feeds only the second stage
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= s.raw;
            sync_q <= meta_q;
        end
    end

    // edge detector looks at the settled copy only
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            prev_q <= '0;
        end else begin
            prev_q <= sync_q;
        end
    end

    assign s.lvl  = sync_q;
    assign s.rise = sync_q & ~prev_q;

    a_sync_two_flop: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        ($stable(s.raw) && $stable($past(s.raw)))
            |=> (s.lvl == $past(s.raw, 2)))
        else $error("synchroniser latency is not two cycles");

    a_rise_single: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        (|s.rise) |=> ((s.rise & $past(s.rise)) == '0))
        else $error("edge strobe lasted longer than one cycle");

endmodule

`default_nettype wire

// [design/drtw_top.sv]
/*
 * drtw_top: debug component lookup table with two read ports and the
 * trigger wiring of three cross-trigger blocks (trace side, fabric,
 * interconnect) joined by a four-channel matrix, plus reset scoping.
 * Assumes one 100 MHz clock; triggers and acks arrive asynchronously.
 */
//
// Behaviour
// - table gives bits 30:12 per entry, 0xD ends
// - debugger reads table at 0x80000000
// - on-chip masters read table at 0xFF000000
// - trace-side inputs wired from macrocell and buffers
// - trace-side outputs drive buffers, macrocell, port
// - only acks 3 and 2 come from port
// - trace-side input acks go to no pin
// - fabric block exposes all its triggers
// - interconnect block exposes all its triggers
// - stall memory buffer before warm/debug reset
// - watchdogs pause while processor is halted
// - domain resets clear their whole clock domain
// - power-on reset only at power-on
// - all cross-trigger blocks share one reset
// - crossings tolerate sync or async clocks
// - trace port clock async to trace bus
// - access port clock equals debug bus clock
// - trace port width set by software write
// - eight triggers, four channels, programmable mapping
`default_nettype none

module drtw_top (
    // clock and reset
    input  wire logic                      ref_clk,
    input  wire logic                      rst_b,
    // debugger lookup port
    input  wire logic                      dbg_rd_req,
    input  wire logic [31:0]               dbg_rd_addr,
    output logic                           dbg_rd_valid_q,
    output logic [31:0]                    dbg_rd_data_q,
    // on-chip master lookup port
    input  wire logic                      soc_rd_req,
    input  wire logic [31:0]               soc_rd_addr,
    output logic                           soc_rd_valid_q,
    output logic [31:0]                    soc_rd_data_q,
    // trace-side event sources
    input  wire logic [3:0]                mc_event_in,
    input  wire logic                      mtb_capture_complete,
    input  wire logic                      mtb_full,
    input  wire logic                      otb_capture_complete,
    input  wire logic                      otb_full,
    // trace-side trigger destinations
    output logic                           otb_trigger_request_in,
    output logic                           otb_flush_request_in,
    output logic [3:0]                     hardware_event_inputs,
    output logic                           tp_trigger_request_in,
    output logic                           tp_flush_request_in,
    output logic                           mtb_trigger_request_in,
    output logic                           mtb_flush_request_in,
    input  wire logic                      tp_trigger_request_ack,
    input  wire logic                      tp_flush_request_ack,
    // fabric triggers
    input  wire logic [7:0]                fab_trig_in,
    output logic [7:0]                     fab_trig_in_ack,
    output logic [7:0]                     fab_trig_out,
    input  wire logic [7:0]                fab_trig_out_ack,
    // interconnect triggers
    input  wire logic [7:0]                l3_trig_in,
    output logic [7:0]                     l3_trig_in_ack,
    output logic [7:0]                     l3_trig_out,
    input  wire logic [7:0]                l3_trig_out_ack,
    // trigger-to-channel mapping, four bits per trigger
    input  wire logic [drtw_pkg::MAP_W-1:0] ts_in_map,
    input  wire logic [drtw_pkg::MAP_W-1:0] ts_out_map,
    input  wire logic [drtw_pkg::MAP_W-1:0] fab_in_map,
    input  wire logic [drtw_pkg::MAP_W-1:0] fab_out_map,
    input  wire logic [drtw_pkg::MAP_W-1:0] l3_in_map,
    input  wire logic [drtw_pkg::MAP_W-1:0] l3_out_map,
    // reset control
    input  wire logic                      warm_reset_req,
    input  wire logic                      debug_reset_req,
    input  wire logic                      mtb_stall_en,
    output logic                           mtb_stall_req_q,
    input  wire logic                      mtb_stall_ack,
    output logic                           trace_bus_reset_n,
    output logic                           cross_trigger_reset_n,
    output logic                           trigger_matrix_reset_n,
    output logic                           trace_port_reset_n,
    output logic                           debug_power_on_reset_n,
    // watchdog pause
    input  wire logic                      cpu_halted,
    input  wire logic                      wdt_pause_en,
    output logic                           wdt_pause_q,
    // trace port setup
    input  wire logic                      tp_clk_sel_in,
    output logic                           tp_clk_sel_q,
    input  wire logic                      psize_wr,
    input  wire logic [drtw_pkg::PSIZE_W-1:0] psize_wdata,
    output logic [drtw_pkg::PSIZE_W-1:0]   trace_port_width_q
);
    import drtw_pkg::*;

    // lookup table read: decode the 4 KB window, zero outside the table
    function automatic logic [31:0] rom_read(logic [31:0] addr,
                                             logic [31:0] base);
        logic [31:0] data;
        logic [ROM_IDX_W-1:0] idx;
        data = '0;
        idx  = addr[ROM_IDX_W+1:2];
        if (addr[31:OFS_LSB] == base[31:OFS_LSB] &&
            addr[OFS_LSB-1:ROM_IDX_W+2] == '0 &&
            32'(idx) < ROM_ENTRIES) begin
            data[OFS_LSB+OFS_W-1:OFS_LSB] = ROM_OFS[idx];
        end
        return data;
    endfunction

    // synchronisers for everything arriving from other domains
    drtw_sync_if #(.W(3*TRIG_W))   in_if ();
    drtw_sync_if #(.W(2*TRIG_W+2)) ack_if ();
    drtw_sync_if #(.W(CTL_W))      ctl_if ();

    assign in_if.raw = {l3_trig_in, fab_trig_in,
                        mc_event_in, mtb_capture_complete, mtb_full,
                        otb_capture_complete, otb_full};
    assign ack_if.raw = {l3_trig_out_ack, fab_trig_out_ack,
                         tp_trigger_request_ack, tp_flush_request_ack};
    assign ctl_if.raw = {tp_clk_sel_in, cpu_halted, mtb_stall_ack,
                         debug_reset_req, warm_reset_req};

    drtw_sync #(.W(3*TRIG_W)) u_in_sync (
        .ref_clk (ref_clk),
        .rst_b   (rst_b),
        .s       (in_if.dst)
    );
    drtw_sync #(.W(2*TRIG_W+2)) u_ack_sync (
        .ref_clk (ref_clk),
        .rst_b   (rst_b),
        .s       (ack_if.dst)
    );
    drtw_sync #(.W(CTL_W)) u_ctl_sync (
        .ref_clk (ref_clk),
        .rst_b   (rst_b),
        .s       (ctl_if.dst)
    );

    logic [TRIG_W-1:0] tin_rise [NUM_CTI];
    logic [TRIG_W-1:0] ack_s    [NUM_CTI];
    logic [TRIG_W-1:0] ack_used [NUM_CTI];
    logic [MAP_W-1:0]  in_map   [NUM_CTI];
    logic [MAP_W-1:0]  out_map  [NUM_CTI];
    logic [TRIG_W-1:0] fire     [NUM_CTI];
    logic [TRIG_W-1:0] out_q    [NUM_CTI];
    logic [CHAN_W-1:0] chan_evt;
    logic              dbg_clr;

    // per-block views of the synchronised vectors
    assign tin_rise[CTI_TS]  = in_if.rise[TRIG_W-1:0];
    assign tin_rise[CTI_FAB] = in_if.rise[2*TRIG_W-1:TRIG_W];
    assign tin_rise[CTI_L3]  = in_if.rise[3*TRIG_W-1:2*TRIG_W];
    assign ack_s[CTI_TS]  = {4'h0, ack_if.lvl[1:0], 2'h0};
    assign ack_s[CTI_FAB] = ack_if.lvl[TRIG_W+1:2];
    assign ack_s[CTI_L3]  = ack_if.lvl[2*TRIG_W+1:TRIG_W+2];
    assign ack_used[CTI_TS]  = TS_ACK_MASK;
    assign ack_used[CTI_FAB] = ALL_ACK_MASK;
    assign ack_used[CTI_L3]  = ALL_ACK_MASK;
    assign in_map[CTI_TS]   = ts_in_map;
    assign in_map[CTI_FAB]  = fab_in_map;
    assign in_map[CTI_L3]   = l3_in_map;
    assign out_map[CTI_TS]  = ts_out_map;
    assign out_map[CTI_FAB] = fab_out_map;
    assign out_map[CTI_L3]  = l3_out_map;

    // channel matrix: any mapped input edge pulses its channels
    always_comb begin
        chan_evt = '0;
        for (int k = 0; k < NUM_CTI; k++) begin
            for (int i = 0; i < TRIG_W; i++) begin
                for (int c = 0; c < CHAN_W; c++) begin
                    chan_evt[c] = chan_evt[c] |
                        (tin_rise[k][i] & in_map[k][i*CHAN_W+c]);
                end
            end
        end
    end

    // a trigger output fires when any of its channels pulses
    always_comb begin
        for (int k = 0; k < NUM_CTI; k++) begin
            for (int i = 0; i < TRIG_W; i++) begin
                fire[k][i] = |(chan_evt & out_map[k][i*CHAN_W +: CHAN_W]);
            end
        end
    end

    // outputs with an ack hold until acked; a new fire beats the ack,
    // outputs whose ack is tied low become one-cycle pulses
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            for (int k = 0; k < NUM_CTI; k++) begin
                out_q[k] <= '0;
            end
        end else begin
            for (int k = 0; k < NUM_CTI; k++) begin
                for (int i = 0; i < TRIG_W; i++) begin
                    if (dbg_clr) begin
                        out_q[k][i] <= 1'b0;
                    end else if (fire[k][i]) begin
                        out_q[k][i] <= 1'b1;
                    end else if (!ack_used[k][i] || ack_s[k][i]) begin
                        out_q[k][i] <= 1'b0;
                    end
                end
            end
        end
    end

    // fixed trace-side destinations
    assign otb_trigger_request_in = out_q[CTI_TS][TO_OTB_TRIG];
    assign otb_flush_request_in   = out_q[CTI_TS][TO_OTB_FLUSH];
    assign hardware_event_inputs  = {{2{out_q[CTI_TS][TO_HWE_HI]}},
                                     {2{out_q[CTI_TS][TO_HWE_LO]}}};
    assign tp_trigger_request_in  = out_q[CTI_TS][TO_TP_TRIG];
    assign tp_flush_request_in    = out_q[CTI_TS][TO_TP_FLUSH];
    assign mtb_trigger_request_in = out_q[CTI_TS][TO_MTB_TRIG];
    assign mtb_flush_request_in   = out_q[CTI_TS][TO_MTB_FLUSH];
    // trace-side input acks stay internal
    assign fab_trig_out   = out_q[CTI_FAB];
    assign fab_trig_in_ack = in_if.lvl[2*TRIG_W-1:TRIG_W];
    assign l3_trig_out    = out_q[CTI_L3];
    assign l3_trig_in_ack = in_if.lvl[3*TRIG_W-1:2*TRIG_W];

    // lookup table answers, one cycle after the request
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            dbg_rd_valid_q <= 1'b0;
            dbg_rd_data_q  <= '0;
            soc_rd_valid_q <= 1'b0;
            soc_rd_data_q  <= '0;
        end else begin
            dbg_rd_valid_q <= dbg_rd_req;
            soc_rd_valid_q <= soc_rd_req;
            if (dbg_rd_req) begin
                dbg_rd_data_q <= rom_read(dbg_rd_addr,
                                          DBG_ROM_BASE);
            end
            if (soc_rd_req) begin
                soc_rd_data_q <= rom_read(soc_rd_addr,
                                          SOC_ROM_BASE);
            end
        end
    end

    // reset sequencer: optional buffer stall, then a timed reset pulse
    drtw_rst_e         rst_st_q;
    logic [HOLD_W-1:0] hold_q;
    logic              rst_req;

    assign rst_req = ctl_if.rise[CTL_WARM] | ctl_if.rise[CTL_DBG];

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_st_q        <= RS_IDLE;
            hold_q          <= '0;
            mtb_stall_req_q <= 1'b0;
        end else begin
            case (rst_st_q)
                RS_IDLE: begin
                    if (rst_req && mtb_stall_en) begin
                        rst_st_q        <= RS_STALL;
                        mtb_stall_req_q <= 1'b1;
                    end else if (rst_req) begin
                        rst_st_q <= RS_HOLD;
                        hold_q   <= HOLD_W'(RST_HOLD_CYC - 1);
                    end
                end
                RS_STALL: begin
                    // the bus master stays quiet until the ack arrives
                    if (ctl_if.lvl[CTL_STLACK]) begin
                        rst_st_q <= RS_HOLD;
                        hold_q   <= HOLD_W'(RST_HOLD_CYC - 1);
                    end
                end
                RS_HOLD: begin
                    if (hold_q == '0) begin
                        rst_st_q        <= RS_IDLE;
                        mtb_stall_req_q <= 1'b0;
                    end else begin
                        hold_q <= hold_q - 1'b1;
                    end
                end
                default: begin
                    rst_st_q        <= RS_IDLE;
                    mtb_stall_req_q <= 1'b0;
                end
            endcase
        end
    end

    assign dbg_clr = (rst_st_q == RS_HOLD);

    // one shared debug reset for every domain and every trigger block
    logic dbg_rst_n_q;
    logic por_n_q;

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            dbg_rst_n_q <= 1'b0;
        end else begin
            dbg_rst_n_q <= !dbg_clr;
        end
    end

    // power-on reset follows rst_b alone, never the sequencer
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            por_n_q <= 1'b0;
        end else begin
            por_n_q <= 1'b1;
        end
    end

    assign trace_bus_reset_n      = dbg_rst_n_q;
    assign cross_trigger_reset_n  = dbg_rst_n_q;
    assign trigger_matrix_reset_n = dbg_rst_n_q;
    assign trace_port_reset_n     = dbg_rst_n_q;
    assign debug_power_on_reset_n = por_n_q;

    // watchdog pause, trace port clock select and width setting;
    // the access port runs on this same clock, so no crossing there
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            wdt_pause_q        <= 1'b0;
            tp_clk_sel_q       <= 1'b0;
            trace_port_width_q <= PSIZE_RST;
        end else begin
            wdt_pause_q  <= wdt_pause_en & ctl_if.lvl[CTL_HALT];
            tp_clk_sel_q <= ctl_if.lvl[CTL_TPCLK];
            if (psize_wr) begin
                trace_port_width_q <= psize_wdata;
            end
        end
    end

    a_rom_first_entry: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        (dbg_rd_req && dbg_rd_addr == DBG_ROM_BASE)
            |=> (dbg_rd_valid_q && dbg_rd_data_q == 32'h0000_1000))
        else $error("debugger read of entry 0 is wrong");

    a_rom_end_mark: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        (dbg_rd_req && dbg_rd_addr == (DBG_ROM_BASE | 32'h0000_0034))
            |=> (dbg_rd_valid_q && dbg_rd_data_q == '0))
        else $error("table end entry is not zero");

    a_soc_rom_read: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        (soc_rd_req && soc_rd_addr == (SOC_ROM_BASE | 32'h0000_0030))
            |=> (soc_rd_data_q == 32'h0040_0000))
        else $error("on-chip read of entry 12 is wrong");

    a_tied_ack_pulse: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        (out_q[CTI_TS][TO_MTB_TRIG] && !fire[CTI_TS][TO_MTB_TRIG])
            |=> !out_q[CTI_TS][TO_MTB_TRIG])
        else $error("tied-ack trigger output did not drop");

    a_tp_trig_hold: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        (tp_trigger_request_in && !ack_if.lvl[1] && !dbg_clr)
            |=> tp_trigger_request_in)
        else $error("trace port trigger dropped before ack");

    a_stall_before_reset: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        (rst_st_q == RS_STALL && !ctl_if.lvl[CTL_STLACK])
            |=> (dbg_rst_n_q && mtb_stall_req_q))
        else $error("reset went ahead before buffer stall ack");

    a_por_never_falls: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        por_n_q |=> por_n_q)
        else $error("power-on reset asserted without rst_b");

    a_shared_reset: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        (!dbg_rst_n_q && dbg_clr)
            |=> (out_q[CTI_FAB] == '0 && out_q[CTI_L3] == '0))
        else $error("trigger state survived the debug reset");

    a_wdt_pause: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        (cpu_halted && wdt_pause_en) [*3] |=> wdt_pause_q)
        else $error("watchdog not paused while halted");

endmodule

`default_nettype wire

// [pkg/drtw_pkg.sv]
/*
 * drtw_pkg: constants, types and the component lookup table for the
 * debug lookup-table and trigger wiring block.
 * Assumes a single 100 MHz reference clock; all figures live here.
 */
`default_nettype none

package drtw_pkg;

    // clock and timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int RST_HOLD_NS   = 160;
    localparam int RST_HOLD_CYC  =
        (RST_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int HOLD_W        = 5;

    // lookup table layout
    localparam int          ROM_ENTRIES  = 14;
    localparam int          ROM_IDX_W    = 4;
    localparam int          OFS_LSB      = 12;
    localparam int          OFS_W        = 19;
    localparam logic [31:0] DBG_ROM_BASE = 32'h8000_0000;
    localparam logic [31:0] SOC_ROM_BASE = 32'hff00_0000;

    typedef logic [OFS_W-1:0] drtw_ofs_t;

    // per-entry base offsets, bits 30:12; last entry ends the table
    localparam drtw_ofs_t ROM_OFS [ROM_ENTRIES] = '{
        19'h00001, 19'h00002, 19'h00003, 19'h00004,
        19'h00005, 19'h00006, 19'h00007, 19'h00008,
        19'h00008, 19'h0000a, 19'h0000b, 19'h00080,
        19'h00400, 19'h00000
    };

    // cross-trigger geometry
    localparam int TRIG_W  = 8;
    localparam int CHAN_W  = 4;
    localparam int NUM_CTI = 3;
    localparam int CTI_TS  = 0;
    localparam int CTI_FAB = 1;
    localparam int CTI_L3  = 2;
    localparam int MAP_W   = TRIG_W * CHAN_W;

    // trace-side trigger input positions
    localparam int TI_MC_LSB   = 4;
    localparam int TI_MTB_DONE = 3;
    localparam int TI_MTB_FULL = 2;
    localparam int TI_OTB_DONE = 1;
    localparam int TI_OTB_FULL = 0;

    // trace-side trigger output positions
    localparam int TO_OTB_TRIG  = 7;
    localparam int TO_OTB_FLUSH = 6;
    localparam int TO_HWE_HI    = 5;
    localparam int TO_HWE_LO    = 4;
    localparam int TO_TP_TRIG   = 3;
    localparam int TO_TP_FLUSH  = 2;
    localparam int TO_MTB_TRIG  = 1;
    localparam int TO_MTB_FLUSH = 0;

    // only the trace port answers; the other acks are tied low
    localparam logic [7:0] TS_ACK_MASK  = 8'h0c;
    localparam logic [7:0] ALL_ACK_MASK = 8'hff;

    // synchronised control levels
    localparam int CTL_W      = 5;
    localparam int CTL_WARM   = 0;
    localparam int CTL_DBG    = 1;
    localparam int CTL_STLACK = 2;
    localparam int CTL_HALT   = 3;
    localparam int CTL_TPCLK  = 4;

    // trace port width setting
    localparam int         PSIZE_W   = 6;
    localparam logic [5:0] PSIZE_RST = 6'h20;

    // reset sequencer
    typedef enum logic [1:0] {
        RS_IDLE  = 2'b00,
        RS_STALL = 2'b01,
        RS_HOLD  = 2'b11
    } drtw_rst_e;

endpackage

`default_nettype wire

// [pkg/drtw_sync_if.sv]
/*
 * drtw_sync_if: a raw level vector and its synchronised copy with a
 * rising-edge strobe. The source drives raw; the synchroniser the rest.
 */
`default_nettype none

interface drtw_sync_if #(parameter int W = 8);
    logic [W-1:0] raw;
    logic [W-1:0] lvl;
    logic [W-1:0] rise;

    modport src (output raw, input lvl, input rise);
    modport dst (input raw, output lvl, output rise);
endinterface

`default_nettype wire

// [tb/drtw_far_model.sv]
/*
 * drtw_far_model: fabric, interconnect, trace port and buffer side
 * acknowledgers. Assumes it shares ref_clk and rst_b with the block.
 */
`default_nettype none

module drtw_far_model (
    // clock and reset
    input  wire logic       ref_clk,
    input  wire logic       rst_b,
    // requests from the block
    input  wire logic [7:0] fab_trig_out,
    input  wire logic [7:0] l3_trig_out,
    input  wire logic       tp_trigger_request_in,
    input  wire logic       tp_flush_request_in,
    input  wire logic       mtb_stall_req_q,
    // answers back
    output logic [7:0]      fab_trig_out_ack,
    output logic [7:0]      l3_trig_out_ack,
    output logic            tp_trigger_request_ack,
    output logic            tp_flush_request_ack,
    output logic            mtb_stall_ack
);
    timeunit 1ns;
    timeprecision 1ps;
    // acks a cycle late, so held requests wait
    always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            {fab_trig_out_ack, l3_trig_out_ack} <= 16'h0000;
            {tp_trigger_request_ack, tp_flush_request_ack} <= 2'b00;
            mtb_stall_ack <= 1'b0;
        end else begin
            {fab_trig_out_ack, l3_trig_out_ack} <= {fab_trig_out, l3_trig_out};
            tp_trigger_request_ack <= tp_trigger_request_in;
            tp_flush_request_ack <= tp_flush_request_in;
            mtb_stall_ack <= mtb_stall_req_q;
        end
    end
endmodule

`default_nettype wire

// [tb/testbench.sv]
/*
 * testbench: random and corner stimulus for drtw_top with a far model.
 * Assumes drtw_pkg, the design and tb/drtw_far_model are compiled first.
 */
`default_nettype none

module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import drtw_pkg::*;
    logic ref_clk = 0, rst_b = 0, dbg_rd_req = 0, soc_rd_req = 0;
    logic [31:0] dbg_rd_addr = 0, soc_rd_addr = 0, dbg_rd_data_q, soc_rd_data_q;
    logic [31:0] ts_in_map = 0, ts_out_map = 0, fab_in_map = 0;
    logic [31:0] fab_out_map = 0, l3_in_map = 0, l3_out_map = 0;
    logic [7:0] fab_trig_in = 0, l3_trig_in = 0, fab_trig_in_ack, fab_trig_out;
    logic [7:0] fab_trig_out_ack, l3_trig_in_ack, l3_trig_out, l3_trig_out_ack;
    logic [3:0] mc_event_in = 0, hardware_event_inputs;
    logic mtb_capture_complete = 0, mtb_full = 0, otb_capture_complete = 0;
    logic otb_full = 0, warm_reset_req = 0, debug_reset_req = 0;
    logic mtb_stall_en = 0, cpu_halted = 0, wdt_pause_en = 0;
    logic tp_clk_sel_in = 0, psize_wr = 0;
    logic [5:0] psize_wdata = 0, trace_port_width_q;
    logic dbg_rd_valid_q, soc_rd_valid_q, otb_trigger_request_in;
    logic otb_flush_request_in, tp_trigger_request_in, tp_flush_request_in;
    logic mtb_trigger_request_in, mtb_flush_request_in, tp_trigger_request_ack;
    logic tp_flush_request_ack, mtb_stall_req_q, mtb_stall_ack, wdt_pause_q;
    logic trace_bus_reset_n, cross_trigger_reset_n, trigger_matrix_reset_n;
    logic trace_port_reset_n, debug_power_on_reset_n, tp_clk_sel_q;
    int cyc, failures, samples_checked, i, j, n, k;
    localparam logic [18:0] OFS [13] = '{19'h1, 19'h2, 19'h3, 19'h4, 19'h5,
        19'h6, 19'h7, 19'h8, 19'h8, 19'ha, 19'hb, 19'h80, 19'h400};

    drtw_top u_dut (.*);
    drtw_far_model u_far (.*);

    // clock and hang guard
    always #5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 5000) begin
            failures++;
            end_of_test();
        end
    end

    task automatic end_of_test;
        $display("checked %0d failed %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic chk(string nm, logic [31:0] s, logic [31:0] e);
        samples_checked++;
        if (s !== e) begin
            failures++;
            $display("ERROR %s expected %h seen %h", nm, e, s);
        end
    endtask

    // past the end marker, entries read zero
    function automatic logic [31:0] rom_word(int x);
        return (x < 13) ? {1'b0, OFS[x], 12'h000} : 32'h0;
    endfunction

    task automatic rd(logic s, logic [31:0] a);
        @(posedge ref_clk);
        {soc_rd_req, dbg_rd_req} <= {s, !s};
        {soc_rd_addr, dbg_rd_addr} <= {a, a};
        @(posedge ref_clk);
        {soc_rd_req, dbg_rd_req} <= 2'b00;
        @(negedge ref_clk);
    endtask

    initial begin
        void'($urandom(32'hfc1cbba7));
        repeat (20) @(posedge ref_clk);
        chk("width rst", trace_port_width_q, 6'h20);
        chk("por rst", debug_power_on_reset_n, 0);
        rst_b <= 1;
        for (j = 0; j < 2; j++) for (i = 0; i < 16; i++) begin
            rd(j, (j ? SOC_ROM_BASE : DBG_ROM_BASE) + 4 * i);
            chk("valid", j ? soc_rd_valid_q : dbg_rd_valid_q, 1);
            chk("entry", j ? soc_rd_data_q : dbg_rd_data_q, rom_word(i));
        end
        $display("lookup test done");
        @(posedge ref_clk);
        {psize_wr, cpu_halted, wdt_pause_en} <= 3'b111;
        psize_wdata <= $urandom;
        tp_clk_sel_in <= $urandom;
        @(posedge ref_clk) psize_wr <= 0;
        repeat (4) @(negedge ref_clk);
        chk("width", trace_port_width_q, psize_wdata);
        chk("tp clk", tp_clk_sel_q, tp_clk_sel_in);
        chk("wdt pause", wdt_pause_q, 1);
        $display("setup test done");
        ts_out_map <= 32'h11111111;
        for (i = 0; i < 8; i++) begin
            @(posedge ref_clk) ts_in_map <= 32'h1 << (i * 4);
            {mc_event_in, mtb_capture_complete, mtb_full, otb_capture_complete,
                otb_full} <= 8'h1 << i;
            repeat (20) if (tp_trigger_request_in !== 1) @(negedge ref_clk);
            chk("ts out", {otb_trigger_request_in, otb_flush_request_in,
                hardware_event_inputs, tp_trigger_request_in,
                tp_flush_request_in, mtb_trigger_request_in,
                mtb_flush_request_in}, 10'h3ff);
            @(posedge ref_clk) {mc_event_in, mtb_capture_complete, mtb_full,
                otb_capture_complete, otb_full} <= 8'h0;
            repeat (12) @(negedge ref_clk);
            chk("tp clear", tp_trigger_request_in, 0);
        end
        $display("trace-side test done");
        j = $urandom_range(7);
        n = $urandom_range(7);
        for (k = 0; k < 2; k++) begin
            @(posedge ref_clk) {fab_in_map, l3_in_map} <= {2{32'h8 << (j * 4)}};
            {fab_out_map, l3_out_map} <= {2{32'h8 << (n * 4)}};
            {l3_trig_in, fab_trig_in} <= k ? {8'h1 << j, 8'h0} : {8'h0, 8'h1 << j};
            repeat (20) if (l3_trig_out[n] !== 1) @(negedge ref_clk);
            chk("fab out", fab_trig_out, 8'h1 << n);
            chk("l3 out", l3_trig_out, 8'h1 << n);
            chk("in ack", k ? l3_trig_in_ack : fab_trig_in_ack, 8'h1 << j);
            @(posedge ref_clk) {l3_trig_in, fab_trig_in} <= 16'h0;
            repeat (12) @(negedge ref_clk);
        end
        $display("fabric test done");
        mtb_stall_en <= 1;
        for (k = 0; k < 2; k++) begin
            @(posedge ref_clk) {debug_reset_req, warm_reset_req} <= k ? 2'b10 : 2'b01;
            repeat (20) if (cross_trigger_reset_n !== 0) @(negedge ref_clk);
            chk("stall", mtb_stall_req_q, 1);
            chk("dom rst", {trace_bus_reset_n, cross_trigger_reset_n,
                trigger_matrix_reset_n, trace_port_reset_n}, 0);
            chk("por", debug_power_on_reset_n, 1);
            @(posedge ref_clk) {debug_reset_req, warm_reset_req} <= 2'b00;
            repeat (40) if (trace_bus_reset_n !== 1) @(negedge ref_clk);
            chk("release", {mtb_stall_req_q, trace_bus_reset_n}, 2'b01);
        end
        $display("reset test done");
        end_of_test();
    end
endmodule

`default_nettype wire
